// ===== logic/rom_cache_pkg.sv
package rom_cache_pkg;
    // Register port geometry
    localparam int REG_ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [REG_ADDR_W-1:0] CTRL_OFFSET = 4'h0;
    localparam logic [REG_ADDR_W-1:0] STATUS_OFFSET = 4'h4;
    // Control word layout
    localparam int FLUSH_BIT = 3;
    localparam int FIXED_ONE_BIT = 0;
    localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000001;
    localparam logic [DATA_W-1:0] CTRL_RSVD_ZERO_MASK = 32'hFFFFFFF6;
    localparam logic [1:0] WORD_ALIGN = 2'h0;
    // Status word layout
    localparam int STAT_BADWR_BIT = 8;
    localparam int FLUSH_CNT_W = 8;
    localparam logic [FLUSH_CNT_W-1:0] FLUSH_CNT_ONE = 8'h01;

    // Registered lookup answer of the tag store
    typedef struct packed {
        logic hit;
        logic miss;
    } fetch_rsp_s;
endpackage : rom_cache_pkg

// ===== logic/rom_cache_tags.sv
`timescale 1ns/100ps
`default_nettype none
module rom_cache_tags
    import rom_cache_pkg::*;
#(
    parameter int INDEX_W = 4,
    parameter int TAG_W = 12
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic flush_in,
    input wire logic fetch_req_in,
    input wire logic [INDEX_W+TAG_W-1:0] fetch_addr_in,
    output fetch_rsp_s rsp_out
);
    localparam int LINES = 1 << INDEX_W;

    logic [LINES-1:0] line_valid;
    logic [LINES-1:0] next_line_valid;
    logic [TAG_W-1:0] line_tag [LINES];
    fetch_rsp_s next_rsp;
    logic [INDEX_W-1:0] index;
    logic [TAG_W-1:0] tag;
    logic lookup_hit;

    assign index = fetch_addr_in[INDEX_W-1:0];
    assign tag = fetch_addr_in[INDEX_W+TAG_W-1:INDEX_W];
    // A flush in the lookup cycle already forces a miss
    assign lookup_hit = line_valid[index] && (line_tag[index] == tag) && !flush_in;

    // Lookup answer
    always_comb begin
        next_rsp.hit = fetch_req_in && lookup_hit;
        next_rsp.miss = fetch_req_in && !lookup_hit;
    end

    // Per-line valid bits: flush clears all, a miss refills its line
    genvar gi;
    generate
        for (gi = 0; gi < LINES; gi++) begin : g_line
            always_comb begin
                next_line_valid[gi] = line_valid[gi];
                if (flush_in) begin
                    next_line_valid[gi] = 1'b0;
                end else if (next_rsp.miss && index == INDEX_W'(gi)) begin
                    next_line_valid[gi] = 1'b1;
                end
            end
            always_ff @(posedge ref_clk_in) begin
                if (!flush_in && next_rsp.miss && index == INDEX_W'(gi)) begin
                    line_tag[gi] <= tag;
                end
            end
        end
    endgenerate

    // State registers
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            line_valid <= '0;
            rsp_out <= '0;
        end else begin
            line_valid <= next_line_valid;
            rsp_out <= next_rsp;
        end
    end
endmodule : rom_cache_tags
`default_nettype wire

// ===== logic/rom_cache_flush_control.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Control word is only accessed as whole aligned 32-bit words.
// - Writing one to bit 3 invalidates every cache entry; the code ignores such a write while standby_in is high.
// - Flush bit always reads back as zero.
// - Writing zero to the flush bit leaves cache contents alone.
// - Power-on reset or standby clears the flush bit state.
// - Bits 31 to 4 are read-only and read as zero.
// - Bit 0 is read-only, reads one; software always writes one there.
module rom_cache_flush_control
    import rom_cache_pkg::*;
#(
    parameter int INDEX_W = 4,
    parameter int TAG_W = 12
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic standby_in,
    input wire logic [REG_ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    input wire logic fetch_req_in,
    input wire logic [INDEX_W+TAG_W-1:0] fetch_addr_in,
    output logic fetch_hit_out,
    output logic fetch_miss_out,
    output logic flush_out
);
    logic ctrl_wr;
    logic stat_wr;
    logic next_flush;
    logic bad_wr;
    logic next_bad_wr;
    logic [FLUSH_CNT_W-1:0] flush_cnt;
    logic [FLUSH_CNT_W-1:0] next_flush_cnt;
    logic [DATA_W-1:0] next_rdata;
    fetch_rsp_s rsp;

    // Decode: only aligned full-word offsets are mapped
    assign ctrl_wr = reg_wr_in && reg_addr_in == CTRL_OFFSET;
    assign stat_wr = reg_wr_in && reg_addr_in == STATUS_OFFSET;

    // Flush trigger, error flag and flush counter
    always_comb begin
        next_flush = ctrl_wr && reg_wdata_in[FLUSH_BIT] && !standby_in;
        next_bad_wr = bad_wr;
        next_flush_cnt = flush_cnt;
        if (stat_wr) begin
            next_bad_wr = 1'b0;
        end
        // Misuse of fixed bits is recorded; set wins over a status write clear, standby clear wins over set
        if (ctrl_wr && ((reg_wdata_in & CTRL_RSVD_ZERO_MASK) != '0 ||
                        !reg_wdata_in[FIXED_ONE_BIT])) begin
            next_bad_wr = 1'b1;
        end
        if (standby_in) begin
            next_bad_wr = 1'b0;
        end
        if (next_flush) begin
            next_flush_cnt = flush_cnt + FLUSH_CNT_ONE;
        end
    end

    // Read mux, answer in the cycle after the strobe
    always_comb begin
        next_rdata = '0;
        if (reg_rd_in && reg_addr_in == CTRL_OFFSET) begin
            next_rdata = CTRL_RESET;
        end else if (reg_rd_in && reg_addr_in == STATUS_OFFSET) begin
            next_rdata[FLUSH_CNT_W-1:0] = flush_cnt;
            next_rdata[STAT_BADWR_BIT] = bad_wr;
        end
    end

    // Registers
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            flush_out <= 1'b0;
            bad_wr <= 1'b0;
            flush_cnt <= '0;
            reg_rdata_out <= '0;
            fetch_hit_out <= 1'b0;
            fetch_miss_out <= 1'b0;
        end else begin
            flush_out <= next_flush;
            bad_wr <= next_bad_wr;
            flush_cnt <= next_flush_cnt;
            reg_rdata_out <= next_rdata;
            fetch_hit_out <= rsp.hit;
            fetch_miss_out <= rsp.miss;
        end
    end

    // Tag store; flush pulse invalidates all lines
    rom_cache_tags #(
        .INDEX_W(INDEX_W),
        .TAG_W(TAG_W)
    ) u_tags (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .flush_in(flush_out),
        .fetch_req_in(fetch_req_in),
        .fetch_addr_in(fetch_addr_in),
        .rsp_out(rsp)
    );

    // Checks
    flush_on_write_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        ctrl_wr && reg_wdata_in[FLUSH_BIT] && !standby_in |=> flush_out)
        else $error("flush write did not pulse flush");
    zero_no_flush_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !(ctrl_wr && reg_wdata_in[FLUSH_BIT]) |=> !flush_out)
        else $error("flush without a one written");
    flush_reads_zero_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        reg_rd_in && reg_addr_in == CTRL_OFFSET |=> !reg_rdata_out[FLUSH_BIT])
        else $error("flush bit read back nonzero");
    upper_zero_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        reg_rd_in && reg_addr_in == CTRL_OFFSET |=> reg_rdata_out[DATA_W-1:FLUSH_BIT+1] == '0)
        else $error("upper control bits not zero");
    fixed_one_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        reg_rd_in && reg_addr_in == CTRL_OFFSET |=> reg_rdata_out[FIXED_ONE_BIT])
        else $error("bit 0 did not read as one");
    standby_clear_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        standby_in |=> !flush_out)
        else $error("flush active after standby");
    unaligned_ignored_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        reg_wr_in && reg_addr_in[1:0] != WORD_ALIGN ##1 !$past(ctrl_wr) |-> !flush_out)
        else $error("unaligned write caused flush");
    miss_after_flush_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        flush_out && fetch_req_in |-> ##2 fetch_miss_out && !fetch_hit_out)
        else $error("hit despite flush");
    refill_then_hit_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        flush_out ##1 fetch_req_in && !flush_out ##1 fetch_req_in && !flush_out
        && $stable(fetch_addr_in) |-> ##2 fetch_hit_out)
        else $error("refilled line did not hit");

    // Register port checks
    idle_rdata_zero_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !reg_rd_in |=> reg_rdata_out == '0)
        else $error("read data present without a read");
    unmapped_read_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        reg_rd_in && reg_addr_in != CTRL_OFFSET && reg_addr_in != STATUS_OFFSET
        |=> reg_rdata_out == '0)
        else $error("unmapped read returned data");
    status_upper_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        reg_rd_in && reg_addr_in == STATUS_OFFSET
        |=> reg_rdata_out[DATA_W-1:STAT_BADWR_BIT+1] == '0)
        else $error("unused status bits not zero");

    // Flush counter and misuse flag checks
    count_step_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        flush_out |-> flush_cnt == $past(flush_cnt) + FLUSH_CNT_ONE)
        else $error("flush count did not step");
    count_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !flush_out |-> $stable(flush_cnt))
        else $error("flush count moved without a flush");
    bad_reserved_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        ctrl_wr && (reg_wdata_in & CTRL_RSVD_ZERO_MASK) != '0 && !standby_in |=> bad_wr)
        else $error("reserved bits written without flag");
    bad_fixed_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        ctrl_wr && !reg_wdata_in[FIXED_ONE_BIT] && !standby_in |=> bad_wr)
        else $error("bit 0 written as zero without flag");
    bad_clear_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        stat_wr |=> !bad_wr)
        else $error("misuse flag not cleared by write");
    bad_standby_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        standby_in |=> !bad_wr)
        else $error("misuse flag kept in standby");

    // Lookup checks
    one_answer_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        fetch_req_in |-> ##2 fetch_hit_out != fetch_miss_out)
        else $error("lookup without exactly one answer");
    no_answer_idle_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !fetch_req_in |-> ##2 !fetch_hit_out && !fetch_miss_out)
        else $error("answer without a lookup");

    // Shadow of lines looked up since the last flush; a first lookup must miss
    localparam int CHK_LINES = 1 << INDEX_W;
    logic [CHK_LINES-1:0] chk_filled;
    logic [CHK_LINES-1:0] next_chk_filled;
    logic [INDEX_W-1:0] chk_index;
    logic chk_first_fetch;

    assign chk_index = fetch_addr_in[INDEX_W-1:0];
    assign chk_first_fetch = fetch_req_in && !chk_filled[chk_index];

    // A flush empties the shadow, a lookup outside a flush cycle fills its line
    always_comb begin
        next_chk_filled = chk_filled;
        if (flush_out) begin
            next_chk_filled = '0;
        end else if (fetch_req_in) begin
            next_chk_filled[chk_index] = 1'b1;
        end
    end

    // Shadow register
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            chk_filled <= '0;
        end else begin
            chk_filled <= next_chk_filled;
        end
    end

    first_fetch_miss_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        chk_first_fetch |-> ##2 fetch_miss_out && !fetch_hit_out)
        else $error("first lookup after a flush hit");

    flush_seen_c: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) flush_out);
    hit_seen_c: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        fetch_hit_out ##1 flush_out ##2 fetch_miss_out);
    bad_write_c: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        $rose(bad_wr));
    flush_fetch_c: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        flush_out && fetch_req_in);
    standby_write_c: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        standby_in && ctrl_wr);
endmodule : rom_cache_flush_control
`default_nettype wire

// ===== verif/rom_cache_flush_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got %h want %h", $time, (a), (b)); end end
module rom_cache_flush_control_tb;
    import rom_cache_pkg::*;
    logic clk = 1'b0, rst = 1'b1, stby = 1'b0, wr = 1'b0, rd = 1'b0, freq = 1'b0;
    logic [REG_ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, q, d;
    logic [15:0] faddr = '0;
    logic hit, miss, flush;
    logic [7:0] fcnt;
    int error_cnt = 0, comparisons = 0;

    rom_cache_flush_control dut_u (.ref_clk_in(clk), .sys_rst_in(rst), .standby_in(stby),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .fetch_req_in(freq), .fetch_addr_in(faddr),
        .fetch_hit_out(hit), .fetch_miss_out(miss), .flush_out(flush));

    // 100 MHz clock
    always #5 clk = ~clk;

    // Verdict and end of run
    task automatic close_out();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // Misuse flag expected for a control word
    function automatic logic exp_bad(input logic [DATA_W-1:0] w);
        return ~w[FIXED_ONE_BIT] | (|(w & CTRL_RSVD_ZERO_MASK));
    endfunction : exp_bad

    // One-cycle write; returns just after the edge where flush_out updates
    task automatic wr_reg(input logic [REG_ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk); wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge clk); wr <= 1'b0; #1;
    endtask : wr_reg

    // One-cycle read; data taken in the cycle after the strobe
    task automatic rd_reg(input logic [REG_ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge clk); rd <= 1'b1; addr <= a;
        @(posedge clk); rd <= 1'b0; #1 v = rdata;
    endtask : rd_reg

    // Lookup; the answer shows two cycles after the request cycle
    task automatic fetch(input logic [15:0] a, input logic exp_hit);
        @(posedge clk); freq <= 1'b1; faddr <= a;
        @(posedge clk); freq <= 1'b0;
        @(posedge clk); #1 `CHK({hit, miss}, {exp_hit, ~exp_hit})
    endtask : fetch

    // Hang guard
    initial begin
        #500000;
        error_cnt++;
        close_out();
    end

    initial begin
        d = $urandom(66);
        fcnt = 8'h00;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd_reg(CTRL_OFFSET, q); `CHK(q, CTRL_RESET)
        fetch(16'h0123, 1'b0);
        fetch(16'h0123, 1'b1);
        wr_reg(CTRL_OFFSET, 32'h00000001); `CHK(flush, 1'b0)
        fetch(16'h0123, 1'b1);
        // Unaligned places are unmapped
        wr_reg(4'h1, 32'h00000009); `CHK(flush, 1'b0)
        rd_reg(4'h2, q); `CHK(q, 32'h00000000)
        // Random control words, every fourth one well formed
        for (int i = 0; i < 24; i++) begin
            d = $urandom;
            if (i % 4 == 0) d = {28'h0000000, d[3], 3'h1};
            wr_reg(CTRL_OFFSET, d); `CHK(flush, d[FLUSH_BIT])
            fcnt = fcnt + {7'h00, d[FLUSH_BIT]};
            if (d[FLUSH_BIT]) begin
                fetch(d[15:0], 1'b0);
                fetch(d[15:0], 1'b1);
            end
            rd_reg(STATUS_OFFSET, q); `CHK(q[8:0], {exp_bad(d), fcnt})
            wr_reg(STATUS_OFFSET, 32'h00000000);
            rd_reg(CTRL_OFFSET, q); `CHK(q, CTRL_RESET)
        end
        // Standby clears the error flag and blocks a flush
        wr_reg(CTRL_OFFSET, 32'h00000000);
        @(posedge clk); stby <= 1'b1;
        wr_reg(CTRL_OFFSET, 32'h00000009); `CHK(flush, 1'b0)
        @(posedge clk); stby <= 1'b0;
        rd_reg(STATUS_OFFSET, q); `CHK(q[8:0], {1'b0, fcnt})
        // Lookups from the flush cycle on: miss, refill miss, then hit
        @(posedge clk); wr <= 1'b1; addr <= CTRL_OFFSET; wdata <= 32'h00000009;
        @(posedge clk); wr <= 1'b0; freq <= 1'b1; faddr <= 16'hBEEF;
        #1 `CHK(flush, 1'b1)
        repeat (2) @(posedge clk);
        #1 `CHK({hit, miss}, 2'b01)
        @(posedge clk); freq <= 1'b0; #1 `CHK({hit, miss}, 2'b01)
        @(posedge clk); #1 `CHK({hit, miss}, 2'b10)
        // Reset in mid-run drops every line and the count
        @(posedge clk); rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        fetch(16'hBEEF, 1'b0);
        rd_reg(STATUS_OFFSET, q); `CHK(q, 32'h00000000)
        rd_reg(CTRL_OFFSET, q); `CHK(q, CTRL_RESET)
        close_out();
    end
endmodule : rom_cache_flush_control_tb
`default_nettype wire
